// *** rtl/rtc_timebase.sv ***
// Purpose: rtc timekeeping core with user copies, alarm and event flags
// Assumes: all inputs synchronous to core_clk_i; slow clock is a level
// Notes:   control bits arrive as plain ports, no register bus
`timescale 1ns/1ps
`include "rtc_defines.svh"

module rtc_timebase
    import rtc_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic        slow_clock_input_i,
    input  wire logic        battery_only_i,
    input  wire logic [6:0]  rate_register_i,
    input  wire logic [7:0]  mode_control_register_i,
    input  wire logic [2:0]  time_sel_i,
    input  wire logic        time_wr_i,
    input  wire logic [7:0]  time_wdata_i,
    input  wire logic [7:0]  alarm_sec_i,
    input  wire logic [7:0]  alarm_min_i,
    input  wire logic [7:0]  alarm_hr_i,
    input  wire logic [7:0]  alarm_dom_i,
    input  wire logic [7:0]  alarm_mon_i,
    input  wire logic        flag_read_i,
    output logic [7:0]       time_rdata_o,
    output logic [7:0]       rate_status_o,
    output logic [7:0]       flag_status_o,
    output logic             irq_o,
    output logic             wake_up_controller_o,
    output logic             osc_active_o
);
    tfield_t     time_q [`T_NUM];
    tfield_t     time_d [`T_NUM];
    tfield_t     nxt    [`T_NUM];
    tfield_t     user_q [`T_NUM];
    logic        sec_tick;
    logic        periodic_evt;
    logic        uip;
    logic        freeze_q;
    logic        xfer_pend_q;
    logic        dst_done_q;
    logic        dst_fall;
    logic        alarm_chk_q;
    logic        alarm_hit;
    logic [7:0]  flags_d;
    logic [39:0] now_pack;
    logic [39:0] alarm_pack;
    logic        bin_mode;
    logic        h24;
    logic        freeze;

    assign bin_mode = mode_control_register_i[`MCR_BINARY];
    assign h24      = mode_control_register_i[`MCR_H24];
    assign freeze   = mode_control_register_i[`MCR_FREEZE];

    rtc_divider u_div (
        .core_clk_i              (core_clk_i),
        .resetn_i                (resetn_i),
        .ce_i                    (ce_i),
        .slow_clock_input_i      (slow_clock_input_i),
        .divider_chain_control_i (rate_register_i[`RATE_DV_HI:`RATE_DV_LO]),
        .rate_sel_i              (rate_register_i[`RATE_RS_HI:`RATE_RS_LO]),
        .sec_tick_o              (sec_tick),
        .periodic_evt_o          (periodic_evt),
        .uip_o                   (uip)
    );

    assign now_pack   = {time_q[`T_MON], time_q[`T_DOM], time_q[`T_HR],
                         time_q[`T_MIN], time_q[`T_SEC]};
    assign alarm_pack = {alarm_mon_i, alarm_dom_i, alarm_hr_i,
                         alarm_min_i, alarm_sec_i};

    rtc_alarm_match u_alarm (
        .now_i   (now_pack),
        .alarm_i (alarm_pack),
        .match_o (alarm_hit)
    );

    // value as a plain binary number, whatever the stored coding
    function automatic tfield_t to_bin(input tfield_t v, input logic bin);
        if (bin) begin
            to_bin = v;
        end else begin
            to_bin = 8'(v[7:4]) * 8'h0a + 8'(v[3:0]);
        end
    endfunction

    // add one in the stored coding
    function automatic tfield_t bump(input tfield_t v, input logic bin);
        if (!bin && v[3:0] == 4'h9) begin
            bump = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bump = v + 8'h01;
        end
    endfunction

    // days in the current month, february stretched in leap years
    function automatic tfield_t month_days(input tfield_t mon,
                                           input tfield_t yr);
        case (mon)
            `MON_FEB: month_days = (yr[1:0] == 2'h0) ? `DAYS_FEB_LEAP
                                                     : `DAYS_FEB;
            `MON_APR, `MON_JUN, `MON_SEP, `MON_NOV:
                month_days = `DAYS_SHORT;
            default:  month_days = `DAYS_LONG;
        endcase
    endfunction

    // one-second step of the whole chain; small values code alike in
    // bcd and binary, so constants like 1 and 3 need no conversion
    always_comb begin
        logic    day_roll;
        logic    at_059;
        tfield_t hv;
        day_roll = 1'b0;
        hv       = '0;
        at_059   = 1'b0;
        for (int i = 0; i < `T_NUM; i++) begin
            nxt[i] = time_q[i];
        end
        dst_fall = 1'b0;
        at_059   = to_bin(time_q[`T_SEC], bin_mode) == `MAX_SEC
                   && to_bin(time_q[`T_MIN], bin_mode) == `MAX_SEC
                   && time_q[`T_HR] == `DST_HR_FROM
                   && time_q[`T_DOW] == `SUNDAY;
        nxt[`T_SEC] = bump(time_q[`T_SEC], bin_mode);
        if (to_bin(time_q[`T_SEC], bin_mode) >= `MAX_SEC) begin
            nxt[`T_SEC] = `TIME_RESET;
            nxt[`T_MIN] = bump(time_q[`T_MIN], bin_mode);
            if (to_bin(time_q[`T_MIN], bin_mode) >= `MAX_SEC) begin
                nxt[`T_MIN] = `TIME_RESET;
                if (h24) begin
                    // 0 .. 23
                    if (to_bin(time_q[`T_HR], bin_mode) >= `MAX_HR24) begin
                        nxt[`T_HR] = `TIME_RESET;
                        day_roll   = 1'b1;
                    end else begin
                        nxt[`T_HR] = bump(time_q[`T_HR], bin_mode);
                    end
                end else begin
                    // 1 .. 12 with the pm flag on top
                    hv = {1'b0, time_q[`T_HR][6:0]};
                    if (to_bin(hv, bin_mode) == `HR12_WRAP) begin
                        nxt[`T_HR] = {time_q[`T_HR][`HR_PM], 7'h01};
                    end else if (to_bin(hv, bin_mode) == `HR12_TURN) begin
                        // a call result cannot be sliced, so park it first
                        hv         = bump(hv, bin_mode);
                        nxt[`T_HR] = {~time_q[`T_HR][`HR_PM], hv[6:0]};
                        day_roll   = time_q[`T_HR][`HR_PM];
                    end else begin
                        nxt[`T_HR] = bump(time_q[`T_HR], bin_mode);
                    end
                end
            end
        end
        if (day_roll) begin
            if (to_bin(time_q[`T_DOW], bin_mode) >= `MAX_DOW) begin
                nxt[`T_DOW] = `DAY_RESET;
            end else begin
                nxt[`T_DOW] = bump(time_q[`T_DOW], bin_mode);
            end
            if (to_bin(time_q[`T_DOM], bin_mode) >=
                month_days(to_bin(time_q[`T_MON], bin_mode),
                           to_bin(time_q[`T_YR], bin_mode))) begin
                nxt[`T_DOM] = `DAY_RESET;
                if (to_bin(time_q[`T_MON], bin_mode) >= `MAX_MON) begin
                    nxt[`T_MON] = `DAY_RESET;
                    if (to_bin(time_q[`T_YR], bin_mode) >= `MAX_YR) begin
                        nxt[`T_YR] = `TIME_RESET;
                    end else begin
                        nxt[`T_YR] = bump(time_q[`T_YR], bin_mode);
                    end
                end else begin
                    nxt[`T_MON] = bump(time_q[`T_MON], bin_mode);
                end
            end else begin
                nxt[`T_DOM] = bump(time_q[`T_DOM], bin_mode);
            end
        end
        // spring: 01:59:59 jumps to 03:00:00 on the first april sunday
        if (mode_control_register_i[`MCR_DST] && at_059
            && to_bin(time_q[`T_MON], bin_mode) == `MON_APR
            && to_bin(time_q[`T_DOM], bin_mode) <= `DST_SPRING_DAY) begin
            nxt[`T_HR] = `DST_HR_TO;
        end
        // fall: the last october sunday repeats the 01 hour once
        if (mode_control_register_i[`MCR_DST] && at_059 && !dst_done_q
            && to_bin(time_q[`T_MON], bin_mode) == `MON_OCT
            && to_bin(time_q[`T_DOM], bin_mode) >= `DST_FALL_DAY) begin
            nxt[`T_HR] = `DST_HR_FROM;
            dst_fall   = 1'b1;
        end
    end

    // internal counters: tick, else transfer from copies; a host write overrides its field unless transferring or frozen
    always_comb begin
        for (int i = 0; i < `T_NUM; i++) begin
            time_d[i] = sec_tick ? nxt[i] : time_q[i];
        end
        if ((xfer_pend_q || (freeze_q && !freeze)) && !sec_tick) begin
            for (int i = 0; i < `T_NUM; i++) begin
                time_d[i] = user_q[i];
            end
        end else if (time_wr_i && !freeze && !freeze_q
                     && time_sel_i < 3'(`T_NUM)) begin
            time_d[time_sel_i] = time_wdata_i;
        end
    end

    // counters, reset to 00:00:00 on day 1 of month 1
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < `T_NUM; i++) begin
                time_q[i] <= (i >= 3 && i <= 5) ? `DAY_RESET : `TIME_RESET;
            end
        end else if (ce_i) begin
            time_q <= time_d;
        end
    end

    // freeze edge tracking; a release that meets a tick waits a cycle
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            freeze_q    <= 1'b0;
            xfer_pend_q <= 1'b0;
        end else if (ce_i) begin
            freeze_q    <= freeze;
            xfer_pend_q <= (xfer_pend_q || (freeze_q && !freeze))
                           && sec_tick;
        end
    end

    // user copies: snapshot on freeze, host writes while frozen
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < `T_NUM; i++) begin
                user_q[i] <= `TIME_RESET;
            end
        end else if (ce_i) begin
            if (freeze && !freeze_q) begin
                user_q <= time_d;
            end else if (freeze && time_wr_i
                         && time_sel_i < 3'(`T_NUM)) begin
                user_q[time_sel_i] <= time_wdata_i;
            end
        end
    end

    // read path: frozen reads see the copies, else the live counters
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            time_rdata_o <= '0;
        end else if (ce_i) begin
            if (time_sel_i >= 3'(`T_NUM)) begin
                time_rdata_o <= '0;
            end else if (freeze_q) begin
                time_rdata_o <= user_q[time_sel_i];
            end else begin
                time_rdata_o <= time_q[time_sel_i];
            end
        end
    end

    // fall-back happens once per year; cleared outside october
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            dst_done_q <= 1'b0;
        end else if (ce_i && sec_tick) begin
            if (dst_fall) begin
                dst_done_q <= 1'b1;
            end else if (to_bin(time_q[`T_MON], bin_mode) != `MON_OCT) begin
                dst_done_q <= 1'b0;
            end
        end
    end

    // compare one cycle after the update so the new time is seen
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            alarm_chk_q <= 1'b0;
        end else if (ce_i) begin
            alarm_chk_q <= sec_tick;
        end
    end

    // sticky flags: a set in the read cycle wins over the clear
    always_comb begin
        flags_d = flag_read_i ? `FLG_RESET : flag_status_o;
        flags_d[`FLG_IRQ] = 1'b0;
        if (sec_tick) begin
            flags_d[`FLG_UF] = 1'b1;
        end
        if (periodic_evt) begin
            flags_d[`FLG_PF] = 1'b1;
        end
        if (alarm_chk_q && alarm_hit) begin
            flags_d[`FLG_AF] = 1'b1;
        end
        flags_d[`FLG_IRQ] =
            (flags_d[`FLG_PF] && mode_control_register_i[`MCR_PIE])
            || (flags_d[`FLG_AF] && mode_control_register_i[`MCR_AIE])
            || (flags_d[`FLG_UF] && mode_control_register_i[`MCR_UIE]);
    end

    // flag register, summary bit and request line
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            flag_status_o <= `FLG_RESET;
            irq_o         <= 1'b0;
        end else if (ce_i) begin
            flag_status_o <= flags_d;
            irq_o         <= flags_d[`FLG_IRQ];
        end
    end

    // alarm level to the wake-up controller follows the alarm flag
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            wake_up_controller_o <= 1'b0;
        end else if (ce_i) begin
            wake_up_controller_o <= flags_d[`FLG_AF];
        end
    end

    // rate register readback with uip on top; oscillator stops only
    // for the stop code while running from the battery alone
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            rate_status_o <= '0;
            osc_active_o  <= 1'b0;
        end else if (ce_i) begin
            rate_status_o <= {uip, rate_register_i};
            osc_active_o  <= !(battery_only_i && rate_register_i
                             [`RATE_DV_HI:`RATE_DV_LO] == `DV_STOP);
        end
    end
endmodule

// *** rtl/rtc_defines.svh ***
// Purpose: offsets, field positions and timing counts of the rtc timebase
// Assumes: slow time base of 32768 Hz sampled on the core clock
// Notes:   definitions only
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// slow time base and divider chain
`define SLOW_HZ          32768
`define SLOW_PERIOD_NS   30518
`define DIV_STAGES       15
`define FIRST_UPDATE_MS  500
`define UIP_LEAD_NS      244000
// least time, rounded to whole slow periods
`define UIP_LEAD_TICKS   ((`UIP_LEAD_NS + `SLOW_PERIOD_NS - 1) / `SLOW_PERIOD_NS)
`define DIV_HALF_COUNT   ((`FIRST_UPDATE_MS * `SLOW_HZ) / 1000)

// rate register fields
`define RATE_UIP         7
`define RATE_DV_HI       6
`define RATE_DV_LO       4
`define RATE_RS_HI       3
`define RATE_RS_LO       0
`define DV_NORMAL        3'h2
`define DV_STOP          3'h0
`define DV_HOLD_TOP      2'h3

// mode control register bits
`define MCR_FREEZE       7
`define MCR_PIE          6
`define MCR_AIE          5
`define MCR_UIE          4
`define MCR_BINARY       2
`define MCR_H24          1
`define MCR_DST          0

// flag status register bits
`define FLG_IRQ          7
`define FLG_PF           6
`define FLG_AF           5
`define FLG_UF           4
`define FLG_RESET        8'h00

// time location indexes
`define T_SEC            3'h0
`define T_MIN            3'h1
`define T_HR             3'h2
`define T_DOW            3'h3
`define T_DOM            3'h4
`define T_MON            3'h5
`define T_YR             3'h6
`define T_NUM            7
`define ALM_FIELDS       5
`define ALM_ANY          2'h3
`define HR_PM            7

// calendar limits, binary values
`define MAX_SEC          8'h3b
`define MAX_HR24         8'h17
`define HR12_WRAP        8'h0c
`define HR12_TURN        8'h0b
`define MAX_DOW          8'h07
`define MAX_MON          8'h0c
`define MAX_YR           8'h63
`define DAYS_LONG        8'h1f
`define DAYS_SHORT       8'h1e
`define DAYS_FEB         8'h1c
`define DAYS_FEB_LEAP    8'h1d
`define MON_FEB          8'h02
`define MON_APR          8'h04
`define MON_JUN          8'h06
`define MON_SEP          8'h09
`define MON_OCT          8'h0a
`define MON_NOV          8'h0b
`define DST_SPRING_DAY   8'h07
`define DST_FALL_DAY     8'h19
`define DST_HR_FROM      8'h01
`define DST_HR_TO        8'h03
`define SUNDAY           8'h01
`define TIME_RESET       8'h00
`define DAY_RESET        8'h01

`endif

// *** rtl/rtc_pkg.sv ***
// Purpose: shared types of the rtc timebase
// Assumes: nothing
// Notes:   numbers live in rtc_defines.svh
package rtc_pkg;
    typedef enum {DIV_STOPPED, DIV_RUNNING, DIV_HELD} div_mode_t;
    typedef logic [7:0] tfield_t;
endpackage

// *** rtl/rtc_divider.sv ***
// Purpose: fifteen stage divider chain, seconds tick, periodic tap, uip
// Assumes: slow clock input is synchronous to the core clock
// Notes:   one slow period is one count of the chain
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_divider
    import rtc_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic        slow_clock_input_i,
    input  wire logic [2:0]  divider_chain_control_i,
    input  wire logic [3:0]  rate_sel_i,
    output logic             sec_tick_o,
    output logic             periodic_evt_o,
    output logic             uip_o
);
    localparam logic [14:0] HALF_CNT = 15'(`DIV_HALF_COUNT);
    localparam logic [14:0] UPD_CNT  = 15'(`DIV_HALF_COUNT + `UIP_LEAD_TICKS);

    div_mode_t   mode;
    logic        slow_q;
    logic        slow_edge;
    logic [14:0] chain_q;
    logic [14:0] chain_d;
    logic [3:0]  tap;

    // decode of the divider control field
    always_comb begin
        if (divider_chain_control_i == `DV_NORMAL) begin
            mode = DIV_RUNNING;
        end else if (divider_chain_control_i[2:1] == `DV_HOLD_TOP) begin
            mode = DIV_HELD;
        end else begin
            mode = DIV_STOPPED;
        end
    end

    assign slow_edge = slow_clock_input_i & ~slow_q;
    assign tap       = rate_sel_i - 4'h1;

    // next chain value: only the normal code lets it count
    always_comb begin
        case (mode)
            DIV_RUNNING: chain_d = slow_edge ? chain_q + 15'h1 : chain_q;
            DIV_HELD:    chain_d = '0;
            DIV_STOPPED: chain_d = chain_q;
            default:     chain_d = chain_q;
        endcase
    end

    // slow clock edge detector, input already synchronous
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            slow_q <= 1'b0;
        end else if (ce_i) begin
            slow_q <= slow_clock_input_i;
        end
    end

    // the divide-by-two stages as one binary count
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            chain_q <= '0;
        end else if (ce_i) begin
            chain_q <= chain_d;
        end
    end

    // seconds tick 500 ms after a start from zero, plus the uip lead
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            sec_tick_o <= 1'b0;
        end else if (ce_i) begin
            sec_tick_o <= (chain_d == UPD_CNT) && (chain_q != UPD_CNT);
        end
    end

    // uip rises the lead time before the update, drops after it
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            uip_o <= 1'b0;
        end else if (ce_i) begin
            if (mode != DIV_RUNNING || sec_tick_o) begin
                uip_o <= 1'b0;
            end else if (chain_d == HALF_CNT && chain_q != HALF_CNT) begin
                uip_o <= 1'b1;
            end
        end
    end

    // a tap bit rising marks the periodic event; first one at half period
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            periodic_evt_o <= 1'b0;
        end else if (ce_i) begin
            periodic_evt_o <= (rate_sel_i != 4'h0) && chain_d[tap]
                              && !chain_q[tap];
        end
    end
endmodule

// *** rtl/rtc_alarm_match.sv ***
// Purpose: compare five time counters with their alarm settings
// Assumes: fields packed seconds lowest, month highest
// Notes:   purely combinational
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_alarm_match
    import rtc_pkg::*;
(
    input  wire logic [39:0] now_i,
    input  wire logic [39:0] alarm_i,
    output logic             match_o
);
    logic [4:0] hit;

    // a field matches on equality or on the don't-care code
    for (genvar f = 0; f < `ALM_FIELDS; f++) begin : g_field
        assign hit[f] = (alarm_i[8*f+6 +: 2] == `ALM_ANY)
                        || (alarm_i[8*f +: 8] == now_i[8*f +: 8]);
    end

    assign match_o = &hit;
endmodule

// *** bench/rtc_timebase_monitor.sv ***
// Purpose: port checker for rtc_timebase
// Assumes: slow clock toggles each core cycle
// Notes:   uip lead bound only fits that fast slow clock
`timescale 1ns/1ps
module rtc_timebase_monitor (
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    input wire logic       ce_i,
    input wire logic       battery_only_i,
    input wire logic [6:0] rate_register_i,
    input wire logic [2:0] time_sel_i,
    input wire logic [7:0] alarm_sec_i,
    input wire logic [7:0] alarm_min_i,
    input wire logic [7:0] alarm_hr_i,
    input wire logic [7:0] alarm_dom_i,
    input wire logic [7:0] alarm_mon_i,
    input wire logic       flag_read_i,
    input wire logic [7:0] time_rdata_o,
    input wire logic [7:0] rate_status_o,
    input wire logic [7:0] flag_status_o,
    input wire logic       irq_o,
    input wire logic       wake_up_controller_o,
    input wire logic       osc_active_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic wild_all;
    // every alarm field set to match anything
    assign wild_all = &{alarm_sec_i[7:6], alarm_min_i[7:6], alarm_hr_i[7:6],
                        alarm_dom_i[7:6], alarm_mon_i[7:6]};
    sequence upd_done; $rose(flag_status_o[4]); endsequence
    sequence alarm_up; flag_status_o[5] && wake_up_controller_o; endsequence
    chk_irq_summary: assert property (irq_o == flag_status_o[7])
        else $error("irq differs from summary");
    chk_summary_cause: assert property (
        flag_status_o[7] |-> |flag_status_o[6:4])
        else $error("summary without flag");
    chk_low_bits: assert property (flag_status_o[3:0] == 4'h0)
        else $error("flag low bits set");
    chk_wake_alarm: assert property (
        wake_up_controller_o == flag_status_o[5])
        else $error("wake differs from alarm flag");
    chk_alarm_wild: assert property (upd_done and wild_all |=> alarm_up)
        else $error("wildcard alarm missed");
    chk_uip_lead: assert property (
        $rose(rate_status_o[7]) |-> ##[15:1000] upd_done)
        else $error("update not after uip");
    chk_rate_echo: assert property (
        ce_i |=> rate_status_o[6:0] == $past(rate_register_i))
        else $error("rate status wrong");
    chk_osc_stop: assert property (ce_i |=> osc_active_o ==
        !($past(battery_only_i) && $past(rate_register_i[6:4]) == 3'h0))
        else $error("oscillator activity wrong");
    chk_unmapped_read: assert property (
        ce_i && time_sel_i == 3'h7 |=> time_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_read_clear: assert property (
        flag_read_i && rate_register_i[3:0] == 4'h0 &&
        $past(rate_register_i[3:0]) == 4'h0 &&
        !rate_status_o[7] && !$past(rate_status_o[7]) &&
        !$past(rate_status_o[7], 2) |=> flag_status_o == 8'h00)
        else $error("flag read did not clear");
endmodule
bind rtc_timebase rtc_timebase_monitor u_rtc_timebase_monitor (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .battery_only_i(battery_only_i), .rate_register_i(rate_register_i),
    .time_sel_i(time_sel_i), .alarm_sec_i(alarm_sec_i),
    .alarm_min_i(alarm_min_i), .alarm_hr_i(alarm_hr_i),
    .alarm_dom_i(alarm_dom_i), .alarm_mon_i(alarm_mon_i),
    .flag_read_i(flag_read_i), .time_rdata_o(time_rdata_o),
    .rate_status_o(rate_status_o), .flag_status_o(flag_status_o),
    .irq_o(irq_o), .wake_up_controller_o(wake_up_controller_o),
    .osc_active_o(osc_active_o));

// *** bench/rtc_timebase_tb.sv ***
// Purpose: self-checking bench for rtc_timebase
// Assumes: slow clock toggled each core cycle to reach an update soon
// Notes:   expected time fields kept in an integer array
`timescale 1ns/1ps
`include "rtc_defines.svh"
module rtc_timebase_tb;
    logic       clk = 0;
    logic       rstn = 0;
    logic       slow = 0;
    logic       batt = 0;
    logic [6:0] rate = 7'h00;
    logic [7:0] mode = 8'h06;
    logic [2:0] sel = 3'h0;
    logic       wr = 0;
    logic [7:0] wd = 8'h00;
    logic [7:0] alm = 8'hc0;
    logic       frd = 0;
    logic [7:0] rdata, rstat, flags;
    logic       irq, wake, osc;
    integer     seed = 32'hb85307b5;
    integer     bad_count = 0;
    integer     checks_done = 0;
    integer     tm [7];
    integer     n;
    integer     t0;
    // bcd 12 h: 11:59:59 pm on 28 february of a leap year, then one
    // second later
    logic [7:0] pre [7] = '{8'h59, 8'h59, 8'h91, 8'h03, 8'h28, 8'h02, 8'h04};
    logic [7:0] post [7] = '{8'h00, 8'h00, 8'h12, 8'h04, 8'h29, 8'h02, 8'h04};
    // 100 ns core clock
    initial forever #50 clk = ~clk;
    // fastest legal slow clock, so the first update stays within the run
    always @(negedge clk) slow <= ~slow;
    rtc_timebase u_rtc_timebase (
        .core_clk_i(clk), .resetn_i(rstn), .ce_i(1'b1),
        .slow_clock_input_i(slow), .battery_only_i(batt),
        .rate_register_i(rate), .mode_control_register_i(mode),
        .time_sel_i(sel), .time_wr_i(wr), .time_wdata_i(wd),
        .alarm_sec_i(alm), .alarm_min_i(alm), .alarm_hr_i(alm),
        .alarm_dom_i(alm), .alarm_mon_i(alm), .flag_read_i(frd),
        .time_rdata_o(rdata), .rate_status_o(rstat), .flag_status_o(flags),
        .irq_o(irq), .wake_up_controller_o(wake), .osc_active_o(osc));
    task automatic cmp(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [2:0] s, input integer e);
        sel = s;
        repeat (2) @(negedge clk);
        cmp("time", e[7:0], rdata);
    endtask
    task automatic wt(input logic [2:0] s, input logic [7:0] d);
        sel = s;
        wd = d;
        wr = 1;
        @(negedge clk) wr = 0;
        // a quiet cycle, so a following write raises the strobe afresh
        @(negedge clk);
        tm[s] = d;
    endtask
    // bounded wait on a flag bit, or on uip when w is 8
    task automatic wait_hi(input int w, input int lim);
        n = 0;
        while (((w == 8) ? rstat[7] : flags[w]) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        cmp("wait", 8'h00, {7'h0, n >= lim});
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        for (n = 0; n < 7; n++) tm[n] = (n >= 3 && n <= 5) ? 1 : 0;
        repeat (10) @(negedge clk);
        rstn = 1;
        @(negedge clk);
        cmp("flags", 8'h00, flags);
        for (int i = 0; i < 7; i++) rd(i[2:0], tm[i]);
        rd(3'h7, 0);
        $display("test reset done");
        batt = 1;
        repeat (2) @(negedge clk);
        cmp("osc", 8'h00, {7'h0, osc});
        batt = 0;
        wt(3'h0, 8'({$random(seed)} % 58));
        wt(3'h1, 8'({$random(seed)} % 60));
        rd(3'h0, tm[0]);
        rd(3'h1, tm[1]);
        $display("test write done");
        // 11x holds the chain at zero: no periodic event may appear
        rate = 7'h61;
        repeat (4) @(negedge clk);
        cmp("flags", 8'h00, flags);
        rate = 7'h21;
        t0 = $time / 100;
        mode = 8'h46;
        wait_hi(6, 20);
        cmp("irq", 8'h01, {7'h0, irq});
        // frozen write lands in the copy, release loads it
        mode = 8'hc6;
        @(negedge clk);
        wt(3'h1, 8'h2a);
        rd(3'h1, 8'h2a);
        mode = 8'h46;
        repeat (2) @(negedge clk);
        rd(3'h1, 8'h2a);
        rate = 7'h20;
        mode = 8'h16;
        repeat (4) @(negedge clk);
        frd = 1;
        @(negedge clk) frd = 0;
        cmp("flags", 8'h00, flags);
        $display("test periodic done");
        // new formats need every time field reloaded
        mode = 8'h30;
        for (int i = 0; i < 7; i++) wt(i[2:0], pre[i]);
        wait_hi(8, 40000);
        wait_hi(4, 100);
        n = $time / 100 - t0 - 2 * (`DIV_HALF_COUNT + `UIP_LEAD_TICKS);
        cmp("first update", 8'h00, {7'h0, n < 0 || n > 1});
        cmp("irq", 8'h01, {7'h0, irq});
        // read while the alarm sets: the set wins, the update flag clears
        frd = 1;
        @(negedge clk) frd = 0;
        cmp("flags", 8'ha0, flags);
        cmp("irq", 8'h01, {7'h0, irq});
        cmp("wake", 8'h01, {7'h0, wake});
        for (int i = 0; i < 7; i++) rd(i[2:0], post[i]);
        $display("test update done");
        summarize();
    end
    // watchdog, about twice the expected run
    initial begin
        #6000000;
        bad_count++;
        summarize();
    end
endmodule
